//--- src/host_link_if.sv
// null-modem link between the device end and the host end
`timescale 1ns/1ps
interface host_link_if;
  logic dev_txd;
  logic dev_rts;
  logic host_txd;
  logic host_rts;
  // crossed: local txd to remote rxd, local rts to remote cts
  modport device (output dev_txd, output dev_rts,
                  input host_txd, input host_rts);
  modport host (output host_txd, output host_rts,
                input dev_txd, input dev_rts);
endinterface

//--- src/host_transport_device.sv
// device end: queued host transport port, debug port, register slave
`timescale 1ns/1ps
module host_transport_device #(
  parameter int DEPTH        = host_uart_pkg::DEPTH,
  parameter int RTS_HEADROOM = 16
) (
  // clock and reset
  input  wire logic        mclk_in,
  input  wire logic        rst_in,
  // avalon-mm slave
  input  wire logic [2:0]  address_in,
  input  wire logic        read_in,
  input  wire logic        write_in,
  input  wire logic [31:0] writedata_in,
  output logic [31:0]      readdata_out,
  output logic             waitrequest_out,
  output logic             irq_out,
  // host transport link
  host_link_if.device      link,
  // debug serial port
  input  wire logic        dbg_rxd_in,
  output logic             dbg_txd_out
);
  localparam int AW = $clog2(DEPTH);
  // level fields are eight bits wide, so the queue stops at 128
  if (DEPTH < 2 || DEPTH > 128 || (1 << AW) != DEPTH
      || RTS_HEADROOM >= DEPTH) begin : g_bad_depth
    $error("depth must be a power of two above headroom");
  end

  typedef struct packed {
    logic        ack;
    logic        wreq;
    logic [31:0] rdata;
    logic        irq;
    logic [AW:0] tx_wp;
    logic [AW:0] tx_rp;
    logic [AW:0] rx_wp;
    logic [AW:0] rx_rp;
    logic [2:0]  istat;
    logic [2:0]  imask;
    logic [4:0]  baud;
    logic        sleep;
    logic [6:0]  rx_thr;
    logic [7:0]  tx_thr;
    logic        rts;
    logic [7:0]  dbg_rx;
  } dev_state_type;

  dev_state_type q_ff;
  dev_state_type nxt_q;
  logic [7:0]    tx_mem [DEPTH];
  logic [7:0]    rx_mem [DEPTH];
  logic [AW:0]   tx_lvl;
  logic [AW:0]   rx_lvl;
  logic          req;
  logic          tx_push;
  logic          tx_pop;
  logic          rx_push;
  logic          rx_pop;
  logic          tx_ready;
  logic [7:0]    rx_byte;
  logic          rx_valid;
  logic          dbg_ready;
  logic [7:0]    dbg_byte;
  logic          dbg_valid;
  logic          dbg_send;

  assign tx_lvl = q_ff.tx_wp - q_ff.tx_rp;
  assign rx_lvl = q_ff.rx_wp - q_ff.rx_rp;
  assign req    = read_in || write_in;
  // request takes effect on the edge where waitrequest is low
  assign tx_push = write_in && q_ff.ack
                   && address_in == host_uart_pkg::REG_DATA
                   && tx_lvl != (AW+1)'(DEPTH);
  assign rx_pop  = read_in && q_ff.ack && address_in == host_uart_pkg::REG_DATA
                   && rx_lvl != '0;
  assign tx_pop  = tx_ready && tx_lvl != '0;
  assign rx_push = rx_valid && rx_lvl != (AW+1)'(DEPTH);
  assign dbg_send = write_in && q_ff.ack
                    && address_in == host_uart_pkg::REG_DEBUG;

  assign readdata_out    = q_ff.rdata;
  assign waitrequest_out = q_ff.wreq;
  assign irq_out         = q_ff.irq;
  assign link.dev_rts    = q_ff.rts;

  ////////////////////////////////////////////////////////////////////////
  serial_char_engine u_host_eng (
    .mclk_in     (mclk_in),
    .rst_in      (rst_in),
    .div_in      (host_uart_pkg::baud_div(q_ff.baud)),
    .tx_data_in  (tx_mem[q_ff.tx_rp[AW-1:0]]),
    .tx_valid_in (tx_lvl != '0),
    .tx_ready_out(tx_ready),
    .cts_in      (link.host_rts),
    .txd_out     (link.dev_txd),
    .rxd_in      (link.host_txd),
    .rx_data_out (rx_byte),
    .rx_valid_out(rx_valid)
  );

  // debug port: one byte at a time, no handshake lines
  serial_char_engine u_dbg_eng (
    .mclk_in     (mclk_in),
    .rst_in      (rst_in),
    .div_in      (host_uart_pkg::baud_div(host_uart_pkg::BAUD_DEFAULT)),
    .tx_data_in  (writedata_in[7:0]),
    .tx_valid_in (dbg_send),
    .tx_ready_out(dbg_ready),
    .cts_in      (1'b1),
    .txd_out     (dbg_txd_out),
    .rxd_in      (dbg_rxd_in),
    .rx_data_out (dbg_byte),
    .rx_valid_out(dbg_valid)
  );

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_q = q_ff;
    nxt_q.ack = req && !q_ff.ack;
    nxt_q.wreq = !nxt_q.ack;
    if (req && !q_ff.ack) begin
      unique case (address_in)
        host_uart_pkg::REG_DATA:   nxt_q.rdata = {24'h0,
                                     rx_mem[q_ff.rx_rp[AW-1:0]]};
        host_uart_pkg::REG_LEVEL:  nxt_q.rdata = {14'h0, q_ff.rts,
                                     link.host_rts, 8'(tx_lvl), 8'(rx_lvl)};
        host_uart_pkg::REG_ISTAT:  nxt_q.rdata = {29'h0, q_ff.istat};
        host_uart_pkg::REG_IMASK:  nxt_q.rdata = {29'h0, q_ff.imask};
        host_uart_pkg::REG_CTRL:   nxt_q.rdata = {23'h0, q_ff.sleep,
                                     3'h0, q_ff.baud};
        host_uart_pkg::REG_THRESH: nxt_q.rdata = {16'h0, q_ff.tx_thr,
                                     1'b0, q_ff.rx_thr};
        host_uart_pkg::REG_DEBUG:  nxt_q.rdata = {23'h0, dbg_ready,
                                     q_ff.dbg_rx};
        default:                   nxt_q.rdata = 32'h0;
      endcase
    end
    if (write_in && q_ff.ack) begin
      unique case (address_in)
        host_uart_pkg::REG_ISTAT:
          nxt_q.istat = q_ff.istat & ~writedata_in[2:0];
        host_uart_pkg::REG_IMASK: nxt_q.imask = writedata_in[2:0];
        host_uart_pkg::REG_CTRL: begin
          // unlisted rate codes are ignored, rate stays
          if (writedata_in[4:0] <= host_uart_pkg::BAUD_LAST) begin
            nxt_q.baud = writedata_in[4:0];
          end
          nxt_q.sleep =
            writedata_in[host_uart_pkg::CTRL_SLEEP_BIT];
        end
        host_uart_pkg::REG_THRESH: begin
          nxt_q.rx_thr = writedata_in[6:0];
          nxt_q.tx_thr = writedata_in[host_uart_pkg::THR_TX_LSB +: 8];
        end
        default: ;
      endcase
    end
    nxt_q.tx_wp = q_ff.tx_wp + (AW+1)'(tx_push);
    nxt_q.tx_rp = q_ff.tx_rp + (AW+1)'(tx_pop);
    nxt_q.rx_wp = q_ff.rx_wp + (AW+1)'(rx_push);
    nxt_q.rx_rp = q_ff.rx_rp + (AW+1)'(rx_pop);
    if (dbg_valid) begin
      nxt_q.dbg_rx = dbg_byte;
    end
    // events set after the clear, so a set in the clearing cycle wins
    if (rx_lvl >= (AW+1)'(q_ff.rx_thr) && q_ff.rx_thr != 7'h0) begin
      nxt_q.istat[host_uart_pkg::IRQ_RX_BIT] = 1'b1;
    end
    if (tx_lvl <= (AW+1)'(q_ff.tx_thr)) begin
      nxt_q.istat[host_uart_pkg::IRQ_TX_BIT] = 1'b1;
    end
    if (rx_valid && !rx_push) begin
      nxt_q.istat[host_uart_pkg::IRQ_OVR_BIT] = 1'b1;
    end
    nxt_q.irq = |(nxt_q.istat & nxt_q.imask);
    // rts only guards queue room, never message pacing; sleep drops rts, halting host sends
    nxt_q.rts = !nxt_q.sleep
                && rx_lvl < (AW+1)'(DEPTH - RTS_HEADROOM);
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      q_ff <= '{baud:   host_uart_pkg::BAUD_DEFAULT,
                wreq:   1'b1,
                rx_thr: host_uart_pkg::RX_THR_RESET,
                tx_thr: host_uart_pkg::TX_THR_RESET,
                imask:  host_uart_pkg::IMASK_RESET,
                default: '0};
    end else begin
      q_ff <= nxt_q;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (tx_push) begin
      tx_mem[q_ff.tx_wp[AW-1:0]] <= writedata_in[7:0];
    end
    if (rx_push) begin
      rx_mem[q_ff.rx_wp[AW-1:0]] <= rx_byte;
    end
  end
endmodule

//--- src/host_transport_host.sv
// host end: one-byte buffers on a plain byte stream
`timescale 1ns/1ps
module host_transport_host (
  // clock and reset
  input  wire logic       mclk_in,
  input  wire logic       rst_in,
  // rate code, same coding as the device
  input  wire logic [4:0] baud_sel_in,
  // transmit stream
  input  wire logic [7:0] tx_data_in,
  input  wire logic       tx_valid_in,
  output logic            tx_ready_out,
  // receive stream and hold-off
  output logic [7:0]      rx_data_out,
  output logic            rx_valid_out,
  input  wire logic       rx_hold_in,
  input  wire logic       link_sleep_in,
  // host transport link
  host_link_if.host       link
);
  typedef struct packed {
    logic       rdy;
    logic       full;
    logic [7:0] buf_byte;
    logic [7:0] rx_byte;
    logic       rx_valid;
    logic       rts;
  } host_state_type;

  host_state_type q_ff;
  host_state_type nxt_q;
  logic           eng_ready;
  logic [7:0]     eng_byte;
  logic           eng_valid;

  assign tx_ready_out  = q_ff.rdy;
  assign rx_data_out   = q_ff.rx_byte;
  assign rx_valid_out  = q_ff.rx_valid;
  assign link.host_rts = q_ff.rts;

  ////////////////////////////////////////////////////////////////////////
  serial_char_engine u_eng (
    .mclk_in     (mclk_in),
    .rst_in      (rst_in),
    .div_in      (host_uart_pkg::baud_div(baud_sel_in)),
    .tx_data_in  (q_ff.buf_byte),
    .tx_valid_in (q_ff.full),
    .tx_ready_out(eng_ready),
    .cts_in      (link.dev_rts),
    .txd_out     (link.host_txd),
    .rxd_in      (link.dev_txd),
    .rx_data_out (eng_byte),
    .rx_valid_out(eng_valid)
  );

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_q = q_ff;
    if (q_ff.full && eng_ready) begin
      nxt_q.full = 1'b0;
    end
    if (tx_valid_in && q_ff.rdy) begin
      nxt_q.full     = 1'b1;
      nxt_q.buf_byte = tx_data_in;
    end
    nxt_q.rdy = !nxt_q.full;
    nxt_q.rx_valid = eng_valid;
    if (eng_valid) begin
      nxt_q.rx_byte = eng_byte;
    end
    // hold-off and link sleep both lower rts
    nxt_q.rts = !rx_hold_in && !link_sleep_in;
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      q_ff <= '0;
    end else begin
      q_ff <= nxt_q;
    end
  end
endmodule

//--- src/host_uart_pkg.sv
// shared constants for the host transport serial link
package host_uart_pkg;
  // clock and frame
  localparam int CLK_HZ    = 25_000_000;
  localparam int DEPTH     = 128;
  localparam int RX_THR_MAX = 127;
  localparam int TX_THR_MAX = 128;
  localparam int DIV_W     = 17;
  localparam int DATA_BITS = 8;
  localparam int STOP_IDX  = DATA_BITS + 1;
  localparam logic [4:0] BAUD_DEFAULT = 5'h06;
  localparam logic [4:0] BAUD_LAST    = 5'h13;
  // register word addresses
  localparam logic [2:0] REG_DATA   = 3'h0;
  localparam logic [2:0] REG_LEVEL  = 3'h1;
  localparam logic [2:0] REG_ISTAT  = 3'h2;
  localparam logic [2:0] REG_IMASK  = 3'h3;
  localparam logic [2:0] REG_CTRL   = 3'h4;
  localparam logic [2:0] REG_THRESH = 3'h5;
  localparam logic [2:0] REG_DEBUG  = 3'h6;
  // field positions
  localparam int CTRL_SLEEP_BIT = 8;
  localparam int THR_TX_LSB     = 8;
  localparam int LVL_CTS_BIT    = 16;
  localparam int LVL_RTS_BIT    = 17;
  localparam int IRQ_RX_BIT     = 0;
  localparam int IRQ_TX_BIT     = 1;
  localparam int IRQ_OVR_BIT    = 2;
  // reset values
  localparam logic [6:0] RX_THR_RESET = 7'h40;
  localparam logic [7:0] TX_THR_RESET = 8'h10;
  localparam logic [2:0] IMASK_RESET  = 3'h0;

  // bit period in clocks for each selectable rate
  function automatic logic [DIV_W-1:0] baud_div(input logic [4:0] sel);
    int rate;
    rate = 57600;
    case (sel)
      5'h00: rate = 921600;
      5'h01: rate = 460800;
      5'h02: rate = 230400;
      5'h03: rate = 153600;
      5'h04: rate = 115200;
      5'h05: rate = 76800;
      5'h06: rate = 57600;
      5'h07: rate = 38400;
      5'h08: rate = 28800;
      5'h09: rate = 19200;
      5'h0a: rate = 14400;
      5'h0b: rate = 9600;
      5'h0c: rate = 7200;
      5'h0d: rate = 4800;
      5'h0e: rate = 2400;
      5'h0f: rate = 1800;
      5'h10: rate = 1200;
      5'h11: rate = 900;
      5'h12: rate = 600;
      5'h13: rate = 300;
      default: rate = 57600;
    endcase
    return DIV_W'(CLK_HZ / rate);
  endfunction
endpackage

//--- src/serial_char_engine.sv
// one character transmitter and receiver, 8n1, lsb first
`timescale 1ns/1ps
module serial_char_engine (
  // clock and reset
  input  wire logic                             mclk_in,
  input  wire logic                             rst_in,
  // bit period in clocks
  input  wire logic [host_uart_pkg::DIV_W-1:0]  div_in,
  // transmit side
  input  wire logic [7:0]                       tx_data_in,
  input  wire logic                             tx_valid_in,
  output logic                                  tx_ready_out,
  input  wire logic                             cts_in,
  output logic                                  txd_out,
  // receive side
  input  wire logic                             rxd_in,
  output logic [7:0]                            rx_data_out,
  output logic                                  rx_valid_out
);
  typedef struct packed {
    logic                            tx_busy;
    logic [3:0]                      tx_bits;
    logic [host_uart_pkg::DIV_W-1:0] tx_cnt;
    logic [9:0]                      tx_sh;
    logic                            rx_busy;
    logic [3:0]                      rx_bits;
    logic [host_uart_pkg::DIV_W-1:0] rx_cnt;
    logic [7:0]                      rx_sh;
    logic                            rx_valid;
  } eng_state_type;

  eng_state_type q_ff;
  eng_state_type nxt_q;
  logic [host_uart_pkg::DIV_W-1:0] rx_target;

  assign tx_ready_out = !q_ff.tx_busy && cts_in;
  assign txd_out      = q_ff.tx_sh[0];
  assign rx_data_out  = q_ff.rx_sh;
  assign rx_valid_out = q_ff.rx_valid;

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_q = q_ff;
    nxt_q.rx_valid = 1'b0;
    // cts checked only at a start: a character in flight always finishes
    if (!q_ff.tx_busy) begin
      if (tx_valid_in && cts_in) begin
        nxt_q.tx_busy = 1'b1;
        nxt_q.tx_bits = 4'h0;
        nxt_q.tx_cnt  = '0;
        nxt_q.tx_sh   = {1'b1, tx_data_in, 1'b0};
      end
    end else if (q_ff.tx_cnt == div_in - 1'b1) begin
      nxt_q.tx_cnt = '0;
      nxt_q.tx_sh  = {1'b1, q_ff.tx_sh[9:1]};
      if (q_ff.tx_bits == 4'(host_uart_pkg::STOP_IDX)) begin
        nxt_q.tx_busy = 1'b0;
      end else begin
        nxt_q.tx_bits = q_ff.tx_bits + 4'h1;
      end
    end else begin
      nxt_q.tx_cnt = q_ff.tx_cnt + 1'b1;
    end
    // start bit sampled mid-bit, then one full period per bit
    rx_target = (q_ff.rx_bits == 4'h0) ? (div_in >> 1) : div_in - 1'b1;
    if (!q_ff.rx_busy) begin
      if (!rxd_in) begin
        nxt_q.rx_busy = 1'b1;
        nxt_q.rx_bits = 4'h0;
        nxt_q.rx_cnt  = '0;
      end
    end else if (q_ff.rx_cnt == rx_target) begin
      nxt_q.rx_cnt  = '0;
      nxt_q.rx_bits = q_ff.rx_bits + 4'h1;
      if (q_ff.rx_bits == 4'h0 && rxd_in) begin
        nxt_q.rx_busy = 1'b0;
      end else if (q_ff.rx_bits == 4'(host_uart_pkg::STOP_IDX)) begin
        // line taken as error free, stop level not checked
        nxt_q.rx_busy  = 1'b0;
        nxt_q.rx_valid = 1'b1;
      end else if (q_ff.rx_bits != 4'h0) begin
        nxt_q.rx_sh = {rxd_in, q_ff.rx_sh[7:1]};
      end
    end else begin
      nxt_q.rx_cnt = q_ff.rx_cnt + 1'b1;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      q_ff <= '{tx_sh: 10'h3ff, default: '0};
    end else begin
      q_ff <= nxt_q;
    end
  end
endmodule

//--- tb/host_uart_monitor.sv
// wire-level checks on the host transport link
`timescale 1ns/1ps
module host_uart_monitor #(
  parameter int DIV = 27
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // link wires
  input wire logic dev_txd,
  input wire logic dev_rts,
  input wire logic host_txd,
  input wire logic host_rts
);
  // frame position per direction, and how long each rts has been low
  int d_cnt;
  int h_cnt;
  int dl_cnt;
  int hl_cnt;

  function automatic int step(input int c, input logic l);
    return (c == 0) ? int'(!l) : (c == 10 * DIV - 1) ? 0 : c + 1;
  endfunction

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      d_cnt  <= 0;
      h_cnt  <= 0;
      dl_cnt <= 0;
      hl_cnt <= 0;
    end else begin
      d_cnt  <= step(d_cnt, dev_txd);
      h_cnt  <= step(h_cnt, host_txd);
      dl_cnt <= dev_rts ? 0 : dl_cnt + 1;
      hl_cnt <= host_rts ? 0 : hl_cnt + 1;
    end
  end

  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (rst_in);

  ////////////////////////////////////////////////////////////////////////////
  property p_txd_rst;
    $fell(rst_in) |-> dev_txd && host_txd;
  endproperty
  property p_dev_rts_rst;
    $fell(rst_in) |-> !dev_rts ##[1:2] dev_rts;
  endproperty
  property p_host_rts_rst;
    $fell(rst_in) |-> !host_rts ##1 host_rts;
  endproperty
  // slack of three cycles allows for input synchronisers
  property p_dev_cts;
    (d_cnt == 0 && !dev_txd) |->
      $past(host_rts, 1) || $past(host_rts, 2) || $past(host_rts, 3);
  endproperty
  property p_host_cts;
    (h_cnt == 0 && !host_txd) |->
      $past(dev_rts, 1) || $past(dev_rts, 2) || $past(dev_rts, 3);
  endproperty
  property p_dev_stop;
    (d_cnt == 9 * DIV + DIV / 2) |-> dev_txd;
  endproperty
  property p_host_stop;
    (h_cnt == 9 * DIV + DIV / 2) |-> host_txd;
  endproperty
  property p_dev_start;
    (d_cnt == 1) |-> !dev_txd [*8];
  endproperty
  property p_host_start;
    (h_cnt == DIV / 2) |-> !host_txd;
  endproperty
  // an in-flight character may finish, nothing after it
  property p_dev_flow;
    (hl_cnt > 10 * DIV + 8) |-> dev_txd && d_cnt == 0;
  endproperty
  property p_host_flow;
    (dl_cnt > 10 * DIV + 8) |-> host_txd && h_cnt == 0;
  endproperty

  a_txd_rst: assert property (p_txd_rst)
    else $error("txd not idle after reset");
  a_dev_rts_rst: assert property (p_dev_rts_rst)
    else $error("device rts wrong after reset");
  a_host_rts_rst: assert property (p_host_rts_rst)
    else $error("host rts wrong after reset");
  a_dev_cts: assert property (p_dev_cts)
    else $error("device started with cts low");
  a_host_cts: assert property (p_host_cts)
    else $error("host started with cts low");
  a_dev_stop: assert property (p_dev_stop)
    else $error("device stop bit low");
  a_host_stop: assert property (p_host_stop)
    else $error("host stop bit low");
  a_dev_start: assert property (p_dev_start)
    else $error("device start bit short");
  a_host_start: assert property (p_host_start)
    else $error("host start bit short");
  a_dev_flow: assert property (p_dev_flow)
    else $error("device kept sending after rts low");
  a_host_flow: assert property (p_host_flow)
    else $error("host kept sending after rts low");

  c_dev_frame: cover property (d_cnt == 10 * DIV - 1);
  c_host_frame: cover property (h_cnt == 10 * DIV - 1);
  c_dev_held: cover property (hl_cnt == 10 * DIV + 9);
  c_host_held: cover property (dl_cnt == 10 * DIV + 9);
endmodule

//--- tb/host_uart_transport_port_tb.sv
// self-checking bench: device end and host end face to face
`timescale 1ns/1ps
module host_uart_transport_port_tb;
  localparam int DIV = 27;
  localparam int DBG_DIV = 434;
  typedef struct { logic [2:0] a; logic [31:0] e; } row_type;
  logic        clk = 1'h0;
  logic        rst = 1'h1;
  logic [2:0]  address = 3'h0;
  logic        rd = 1'h0;
  logic        wr = 1'h0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic [31:0] v;
  logic        wait_req;
  logic        irq;
  logic        dbg_line;
  logic [4:0]  baud_sel = 5'h00;
  logic [7:0]  h_txd = 8'h00;
  logic [7:0]  h_rxd;
  logic        h_txv = 1'h0;
  logic        h_rdy;
  logic        h_rxv;
  logic        hold = 1'h0;
  logic        sleep = 1'h0;
  logic [7:0]  hq[$];
  row_type     rows[6];
  int          err_total = 0;
  int          tests_run = 0;
  int          lows;

  host_link_if lnk ();
  host_transport_device i_host_transport_device (
    .mclk_in(clk), .rst_in(rst), .address_in(address), .read_in(rd),
    .write_in(wr), .writedata_in(wdata), .readdata_out(rdata),
    .waitrequest_out(wait_req), .irq_out(irq), .link(lnk.device),
    .dbg_rxd_in(dbg_line), .dbg_txd_out(dbg_line));
  host_transport_host i_host_transport_host (
    .mclk_in(clk), .rst_in(rst), .baud_sel_in(baud_sel),
    .tx_data_in(h_txd), .tx_valid_in(h_txv), .tx_ready_out(h_rdy),
    .rx_data_out(h_rxd), .rx_valid_out(h_rxv), .rx_hold_in(hold),
    .link_sleep_in(sleep), .link(lnk.host));
  host_uart_monitor #(.DIV(DIV)) i_host_uart_monitor (
    .mclk_in(clk), .rst_in(rst), .dev_txd(lnk.dev_txd),
    .dev_rts(lnk.dev_rts), .host_txd(lnk.host_txd),
    .host_rts(lnk.host_rts));

  initial begin
    forever #20 clk = ~clk;
  end
  // no host rx buffer: the pulse is caught at once
  always @(negedge clk) begin
    if (h_rxv === 1'h1) hq.push_back(h_rxd);
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [2:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    address <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    do begin
      @(posedge clk);
      n++;
    end while (wait_req !== 1'h0 && n < 100);
    if (n >= 100) err_total++;
    v = rdata;
    wr <= 1'h0;
    rd <= 1'h0;
  endtask

  task automatic host_tx(input logic [7:0] b);
    int n;
    n = 0;
    @(posedge clk);
    h_txd <= b;
    h_txv <= 1'h1;
    do begin
      @(negedge clk);
      n++;
    end while (h_rdy !== 1'h1 && n < 20000);
    if (n >= 20000) err_total++;
    @(posedge clk);
    h_txv <= 1'h0;
  endtask

  task automatic q_chk(input logic [31:0] b);
    int k;
    k = 0;
    while (hq.size() == 0 && k < 20000) begin
      @(negedge clk);
      k++;
    end
    chk({24'h0, hq.size() != 0 ? hq.pop_front() : 8'hxx}, b);
  endtask

  task automatic wire_chk(input logic [7:0] b);
    logic [9:0] got;
    int k;
    k = 0;
    while (lnk.dev_txd !== 1'h0 && k < 2000) begin
      @(negedge clk);
      k++;
    end
    repeat (DIV / 2) @(negedge clk);
    for (int i = 0; i < 10; i++) begin
      got[i] = lnk.dev_txd;
      repeat (DIV) @(negedge clk);
    end
    chk({22'h0, got}, {22'h0, 1'h1, b, 1'h0});
  endtask

  task automatic reset_rows();
    repeat (4) @(posedge clk);
    foreach (rows[i]) begin
      bus(1'h0, rows[i].a, 32'h0);
      chk(v, rows[i].e);
    end
    chk({31'h0, irq}, 32'h0);
    $display("test reset values done");
  endtask

  task automatic results();
    $display("tests_run=%0d err_total=%0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rows[0] = '{host_uart_pkg::REG_LEVEL, 32'h0003_0000};
    rows[1] = '{host_uart_pkg::REG_ISTAT, 32'h0000_0002};
    rows[2] = '{host_uart_pkg::REG_IMASK, 32'h0000_0000};
    rows[3] = '{host_uart_pkg::REG_CTRL, 32'h0000_0006};
    rows[4] = '{host_uart_pkg::REG_THRESH, 32'h0000_1040};
    rows[5] = '{3'h7, 32'h0};
    repeat (8) @(posedge clk);
    rst <= 1'h0;
    reset_rows();
    // every rate code, then one past the table
    for (int c = 0; c < 20; c++) begin
      bus(1'h1, host_uart_pkg::REG_CTRL, 32'(c));
      bus(1'h0, host_uart_pkg::REG_CTRL, 32'h0);
      chk(v, 32'(c));
    end
    bus(1'h1, host_uart_pkg::REG_CTRL, 32'h14);
    bus(1'h0, host_uart_pkg::REG_CTRL, 32'h0);
    chk(v, 32'h13);
    bus(1'h1, host_uart_pkg::REG_CTRL, 32'h0);
    $display("test rate codes done");
    fork
      wire_chk(8'h35);
      begin
        bus(1'h1, host_uart_pkg::REG_DATA, 32'h35);
        bus(1'h1, host_uart_pkg::REG_DATA, 32'h00);
        bus(1'h1, host_uart_pkg::REG_DATA, 32'hff);
      end
    join
    q_chk(32'h35);
    q_chk(32'h00);
    q_chk(32'hff);
    $display("test device to host done");
    bus(1'h1, host_uart_pkg::REG_THRESH, 32'h1003);
    bus(1'h1, host_uart_pkg::REG_IMASK, 32'h1);
    for (int i = 1; i < 4; i++) host_tx(8'(8'h11 * i));
    // two whole frames still follow the last buffered byte
    repeat (25 * DIV) @(negedge clk);
    chk({31'h0, irq}, 32'h1);
    bus(1'h0, host_uart_pkg::REG_LEVEL, 32'h0);
    chk(v & 32'hff, 32'h3);
    for (int i = 1; i < 4; i++) begin
      bus(1'h0, host_uart_pkg::REG_DATA, 32'h0);
      chk(v & 32'hff, 32'(32'h11 * i));
    end
    bus(1'h1, host_uart_pkg::REG_ISTAT, 32'h1);
    repeat (3) @(negedge clk);
    chk({31'h0, irq}, 32'h0);
    bus(1'h1, host_uart_pkg::REG_IMASK, 32'h2);
    repeat (3) @(negedge clk);
    chk({31'h0, irq}, 32'h1);
    bus(1'h1, host_uart_pkg::REG_IMASK, 32'h0);
    repeat (3) @(negedge clk);
    chk({31'h0, irq}, 32'h0);
    $display("test host to device done");
    // host holds off the device, first by hold then by link sleep
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      hold <= (k == 0);
      sleep <= (k == 1);
      repeat (4) @(posedge clk);
      bus(1'h1, host_uart_pkg::REG_DATA, 32'ha0 + 32'(k));
      lows = 0;
      repeat (30 * DIV) begin
        @(negedge clk);
        if (lnk.dev_txd !== 1'h1) lows++;
      end
      chk(32'(lows), 32'h0);
      @(posedge clk);
      hold <= 1'h0;
      sleep <= 1'h0;
      q_chk(32'ha0 + 32'(k));
    end
    bus(1'h1, host_uart_pkg::REG_CTRL, 32'h100);
    bus(1'h0, host_uart_pkg::REG_LEVEL, 32'h0);
    chk(v & 32'h2_0000, 32'h0);
    host_tx(8'h3c);
    repeat (30 * DIV) @(negedge clk);
    bus(1'h0, host_uart_pkg::REG_LEVEL, 32'h0);
    chk(v & 32'hff, 32'h0);
    bus(1'h1, host_uart_pkg::REG_CTRL, 32'h0);
    repeat (15 * DIV) @(negedge clk);
    bus(1'h0, host_uart_pkg::REG_DATA, 32'h0);
    chk(v & 32'hff, 32'h3c);
    $display("test flow control done");
    bus(1'h1, host_uart_pkg::REG_DEBUG, 32'h5a);
    repeat (11 * DBG_DIV) @(negedge clk);
    bus(1'h0, host_uart_pkg::REG_DEBUG, 32'h0);
    chk(v & 32'hff, 32'h5a);
    $display("test debug port done");
    // reset lands in mid-frame
    bus(1'h1, host_uart_pkg::REG_DATA, 32'h77);
    repeat (5 * DIV) @(posedge clk);
    rst <= 1'h1;
    repeat (3) @(posedge clk);
    rst <= 1'h0;
    hq.delete();
    reset_rows();
    results();
  end

  initial begin
    repeat (30000) @(posedge clk);
    err_total++;
    results();
  end
endmodule
